//--- pdr_pkg.sv
package pdr_pkg;
	localparam logic [19:0] DRAM_TOP = 20'h3ffff;
	localparam logic [19:0] BOOT_LO = 20'hf0000;
	localparam logic [19:0] BOOT_HI = 20'hfffff;
	localparam int ROW_W = 9;
	localparam int ADDR_W = 18;
	localparam logic [8:0] REFRESH_STEP = 9'h100;
	localparam int CLOCK_HZ = 10000000;
	localparam int REFRESH_MS = 4;
	localparam int REFRESH_CYCLES = CLOCK_HZ / 1000 * REFRESH_MS;
	localparam int REFRESH_PAIRS = 256;
	localparam int REFRESH_GAP = REFRESH_CYCLES / REFRESH_PAIRS;
	localparam logic [3:0] RESET_HOLD = 4'h4;

	typedef enum logic [2:0] {
		PDR_IDLE = 3'b000,
		PDR_ROW = 3'b001,
		PDR_COL = 3'b010,
		PDR_REF1 = 3'b011,
		PDR_REF_GAP = 3'b100,
		PDR_REF2 = 3'b101,
		PDR_DONE = 3'b110
	} pdr_state_t;

	typedef struct packed {
		logic sel_low_n;
		logic sel_up_n;
		logic rd_n;
		logic wr_n;
		logic ale;
		logic ext_strobe;
		logic refresh_ack;
		logic [15:0] ad;
		logic [3:0] a_hi;
	} pdr_bus_t;

	typedef struct packed {
		logic ras_n;
		logic cas_n;
		logic dram_we_n;
		logic [8:0] ma;
		logic nmi;
		logic boot_oe_n;
		logic board_reset;
		logic system_clock_out;
		logic refresh_req;
	} pdr_out_t;
endpackage

//--- pdr_ctrl.sv
`timescale 1ns/1ps
module pdr_ctrl #(
	parameter int REFRESH_INTERVAL = pdr_pkg::REFRESH_GAP
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic reset_in,
	input wire pdr_pkg::pdr_bus_t bus,
	input wire logic bus_request,
	input wire logic [7:0] dram_data,
	input wire logic dram_par,
	output logic hold_out,
	output logic hold_grant_out,
	output logic dram_par_out,
	output pdr_pkg::pdr_out_t outs
);
	import pdr_pkg::*;

	// parameter sanity, refused at elaboration
	if (REFRESH_INTERVAL < 8 || REFRESH_INTERVAL > 65535) begin
		$error("refresh interval out of range");
	end
	// row and column halves must cover the latched address
	if (2 * ROW_W != ADDR_W) begin
		$error("address halves do not cover the address width");
	end
	// a zero stretch would drop the board reset too early
	if (RESET_HOLD == 4'h0) begin
		$error("board reset stretch must be nonzero");
	end

	typedef struct packed {
		pdr_state_t state;
		logic [1:0] rst_sync;
		logic [1:0] bus_sync;
		logic [17:0] addr;
		logic [1:0] ext_bits;
		logic [8:0] ref_row;
		logic [15:0] ref_cnt;
		logic [3:0] rst_cnt;
		logic access_wr;
		logic rd_q;
		logic grant;
		logic par_gen;
		logic par_err;
		pdr_out_t o;
	} pdr_reg_t;

	pdr_reg_t r;
	pdr_reg_t next_r;
	logic low_hit;
	logic par_calc;
	logic acc_req;
	logic ref_take;
	logic timer_zero;
	logic rd_cycle;
	logic par_bad;
	logic [8:0] row_half;
	logic [8:0] col_half;
	logic [8:0] ref_row_b;
	logic [15:0] timer_next;

	// address decode, address halves and parity of returned byte
	always_comb begin
		low_hit = !bus.sel_low_n && ({2'b00, r.addr} <= DRAM_TOP);
		par_calc = ^dram_data;
		// request qualifiers seen in idle
		acc_req = low_hit && (!bus.rd_n || !bus.wr_n);
		ref_take = bus.refresh_ack;
		// row half from low bits, column half carries a16 and a17
		row_half = r.addr[ROW_W-1:0];
		col_half = r.addr[ADDR_W-1:ROW_W];
		// second refresh row sits half the array away
		ref_row_b = r.ref_row + REFRESH_STEP;
		// refresh timer reload and count down
		timer_zero = (r.ref_cnt == 16'h0000);
		if (timer_zero) begin
			timer_next = 16'(REFRESH_INTERVAL - 1);
		end else begin
			timer_next = r.ref_cnt - 16'h0001;
		end
		// read cycle qualifier and stored parity compare
		rd_cycle = !r.o.cas_n && r.o.dram_we_n;
		par_bad = r.rd_q && (par_calc != dram_par);
	end

	// state machine and registered outputs
	always_comb begin
		next_r = r;
		next_r.rst_sync = {r.rst_sync[0], reset_in};
		next_r.bus_sync = {r.bus_sync[0], bus_request};
		next_r.o.system_clock_out = !r.o.system_clock_out;
		next_r.o.boot_oe_n = !(!bus.sel_up_n && !bus.rd_n);
		// board reset held while reset_in is low, then six cycles after it returns high
		if (!r.rst_sync[1]) begin
			next_r.rst_cnt = RESET_HOLD;
		end else if (r.rst_cnt != 4'h0) begin
			next_r.rst_cnt = r.rst_cnt - 4'h1;
		end
		next_r.o.board_reset = !r.rst_sync[1] || (r.rst_cnt != 4'h0);
		// bus request passes to hold, grant returns
		next_r.grant = r.bus_sync[1];
		// address capture while ale is asserted
		if (bus.ale) begin
			next_r.addr[15:0] = bus.ad;
			next_r.addr[17:16] = r.ext_bits;
		end
		if (bus.ext_strobe) begin
			next_r.ext_bits = bus.a_hi[1:0];
			next_r.addr[17:16] = bus.a_hi[1:0];
		end
		// refresh timer counts down every cycle
		next_r.ref_cnt = timer_next;
		// parity check on read data, error sticky until reset
		next_r.rd_q = rd_cycle;
		if (par_bad) begin
			next_r.par_err = 1'b1;
		end
		next_r.o.nmi = r.par_err;
		// sequencer for memory access and refresh
		case (r.state)
		PDR_IDLE: begin
			// strobes rest high between cycles
			next_r.o.ras_n = 1'b1;
			next_r.o.cas_n = 1'b1;
			next_r.o.dram_we_n = 1'b1;
			if (ref_take) begin
				// refresh transfer: row only, no deposit write
				next_r.o.refresh_req = 1'b0;
				next_r.o.ma = r.ref_row;
				next_r.o.ras_n = 1'b0;
				next_r.state = PDR_REF1;
			end else if (acc_req) begin
				// cpu or disk master access, row half first
				next_r.access_wr = !bus.wr_n;
				next_r.o.ma = row_half;
				next_r.o.ras_n = 1'b0;
				next_r.state = PDR_ROW;
			end
		end
		PDR_ROW: begin
			// column half under cas, write enable only for writes
			next_r.o.ma = col_half;
			next_r.o.cas_n = 1'b0;
			next_r.o.dram_we_n = !r.access_wr;
			next_r.par_gen = par_calc;
			next_r.state = PDR_COL;
		end
		PDR_COL: begin
			// strobes stand until both commands end
			if (bus.rd_n && bus.wr_n) begin
				next_r.o.ras_n = 1'b1;
				next_r.o.cas_n = 1'b1;
				next_r.o.dram_we_n = 1'b1;
				next_r.state = PDR_IDLE;
			end
		end
		PDR_REF1: begin
			// precharge between the two refresh rows
			next_r.o.ras_n = 1'b1;
			next_r.state = PDR_REF_GAP;
		end
		PDR_REF_GAP: begin
			// second row of the pair
			next_r.o.ma = ref_row_b;
			next_r.o.ras_n = 1'b0;
			next_r.state = PDR_REF2;
		end
		PDR_REF2: begin
			// end of pair, step to the next row
			next_r.o.ras_n = 1'b1;
			next_r.ref_row = r.ref_row + 9'h001;
			next_r.state = PDR_DONE;
		end
		PDR_DONE: begin
			// wait for the channel to drop its acknowledge
			if (!bus.refresh_ack) begin
				next_r.state = PDR_IDLE;
			end
		end
		default: begin
			next_r.state = PDR_IDLE;
		end
		endcase
		// timer tick set last, so it wins over the clear
		if (timer_zero) begin
			next_r.o.refresh_req = 1'b1;
		end
	end

	// single state register, synchronous reset
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			r <= '0;
			r.state <= PDR_IDLE;
			r.o.ras_n <= 1'b1;
			r.o.cas_n <= 1'b1;
			r.o.dram_we_n <= 1'b1;
			r.o.boot_oe_n <= 1'b1;
			r.o.board_reset <= 1'b1;
			r.ref_cnt <= 16'h0000;
		end else begin
			r <= next_r;
		end
	end

	assign outs = r.o;
	assign hold_out = r.bus_sync[1];
	assign hold_grant_out = r.grant;
	assign dram_par_out = r.par_gen;
endmodule

//--- pdr_assertions.sv
`timescale 1ns/1ps
module pdr_assertions #(
	parameter int REFRESH_INTERVAL = pdr_pkg::REFRESH_GAP
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic reset_in,
	input wire pdr_pkg::pdr_bus_t bus,
	input wire logic bus_request,
	input wire logic [7:0] dram_data,
	input wire logic dram_par,
	input wire logic hold_out,
	input wire logic hold_grant_out,
	input wire logic dram_par_out,
	input wire pdr_pkg::pdr_out_t outs
);
	import pdr_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	property p_sel;
		$fell(outs.ras_n) |-> $past(!bus.sel_low_n || bus.refresh_ack);
	endproperty
	a_sel: assert property (p_sel) else $error("row strobe unselected");
	property p_col;
		$fell(outs.ras_n) && !bus.refresh_ack |=> $fell(outs.cas_n);
	endproperty
	a_col: assert property (p_col) else $error("column late");
	property p_pair;
		$fell(outs.ras_n) && bus.refresh_ack && $past(outs.ras_n, 2) |->
			##2 $fell(outs.ras_n) && outs.ma == $past(outs.ma, 2) + 9'h100;
	endproperty
	a_pair: assert property (p_pair) else $error("second row");
	property p_nowr;
		bus.refresh_ack |-> outs.cas_n && outs.dram_we_n;
	endproperty
	a_nowr: assert property (p_nowr) else $error("refresh wrote");
	property p_boot;
		!outs.boot_oe_n |-> $past(!bus.sel_up_n && !bus.rd_n);
	endproperty
	a_boot: assert property (p_boot) else $error("boot enable");
	property p_hold;
		outs.nmi |=> outs.nmi;
	endproperty
	a_hold: assert property (p_hold) else $error("nmi dropped");
	property p_perr;
		$rose(outs.nmi) |-> $past(!outs.cas_n, 2) || $past(!outs.cas_n, 3);
	endproperty
	a_perr: assert property (p_perr) else $error("nmi no read");
	property p_brst;
		$rose(reset_in) |-> outs.board_reset [*5];
	endproperty
	a_brst: assert property (p_brst) else $error("board reset");
endmodule
bind pdr_ctrl pdr_assertions #(.REFRESH_INTERVAL(REFRESH_INTERVAL)) u_chk(.*);

//--- pdr_host.sv
`timescale 1ns/1ps
module pdr_host (
	input wire logic clock,
	input wire logic bad,
	input wire logic dram_par_out,
	input wire pdr_pkg::pdr_out_t outs,
	output pdr_pkg::pdr_bus_t bus,
	output logic [7:0] dram_data,
	output logic [0:0] dram_par
);
	import pdr_pkg::*;
	logic par = 0;
	initial bus = 27'h7800000; // all strobes idle
	assign dram_data = 8'h5a;
	assign dram_par = par ^ bad;
	// stored parity bit of the array
	always @(posedge clock) if (!outs.cas_n && !outs.dram_we_n) par <= dram_par_out;
	// one cpu access, address then strobes for four cycles
	task acc(input [19:0] a, input w, input e);
		@(negedge clock);
		bus.ad = a[15:0];
		bus.a_hi = e ? a[19:16] : a[19:16] ^ 4'h3;
		{bus.ale, bus.ext_strobe} = {1'b1, e};
		@(negedge clock);
		{bus.ale, bus.ext_strobe} = 2'h0;
		bus.sel_low_n = (a > DRAM_TOP); // processor window decode
		bus.ad = ~bus.ad;
		if (w) bus.wr_n = 0;
		else bus.rd_n = 0;
		repeat (4) @(negedge clock);
		{bus.sel_low_n, bus.rd_n, bus.wr_n} = 3'h7;
	endtask
	// refresh channel answers the timer request
	task rfr;
		wait (outs.refresh_req);
		@(negedge clock) bus.refresh_ack = 1;
		repeat (6) @(negedge clock);
		bus.refresh_ack = 0;
	endtask
	task up(input [1:0] v);
		@(negedge clock) {bus.sel_up_n, bus.rd_n} = v;
		repeat (2) @(negedge clock);
	endtask
endmodule

//--- pdr_ctrl_test.sv
`timescale 1ns/1ps
`define CHK(n,s,e) begin compares++; if ((s) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module pdr_ctrl_test;
	import pdr_pkg::*;
	logic clock = 0, rst_n, reset_in, bus_request, bad, hold_out;
	logic hold_grant_out, dram_par_out, c, rp = 1, cp = 1, wp = 1;
	logic [7:0] dram_data;
	logic [0:0] dram_par;
	pdr_bus_t bus;
	pdr_out_t outs;
	logic [8:0] rows[$], cols[$];
	int n_mismatch = 0, compares = 0, wr_falls = 0;
	always #50 clock = ~clock;
	pdr_ctrl #(.REFRESH_INTERVAL(40)) dut(.clock, .rst_n, .reset_in, .bus,
		.bus_request, .dram_data, .dram_par, .hold_out, .hold_grant_out,
		.dram_par_out, .outs);
	pdr_host h(.clock, .bad, .dram_par_out, .outs, .bus, .dram_data, .dram_par);
	// record address halves at each strobe fall
	always @(negedge clock) begin
		if (!outs.ras_n && rp) rows.push_back(outs.ma);
		if (!outs.cas_n && cp) cols.push_back(outs.ma);
		if (!outs.dram_we_n && wp) wr_falls++;
		{rp, cp, wp} = {outs.ras_n, outs.cas_n, outs.dram_we_n};
	end
	task test_done;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task t_acc;
		h.acc(20'h3ffff, 1, 1);
		h.acc(20'h30155, 1, 0);
		h.acc(20'h40000, 0, 1);
		h.acc(20'h00000, 1, 1);
		`CHK("accesses", rows.size(), 3)
		`CHK("writes", wr_falls, 3)
		`CHK("row", rows[1], 9'h155)
		`CHK("col", cols[0], 9'h1ff)
		`CHK("kept", cols[1], 9'h180)
	endtask
	task t_ref;
		repeat (40) @(negedge clock);
		`CHK("request", outs.refresh_req, 1'b1)
		rows = {};
		cols = {};
		wr_falls = 0;
		h.rfr;
		h.rfr;
		`CHK("no write", wr_falls, 0)
		`CHK("pair", rows[1], rows[0] + 9'h100)
		`CHK("next", rows[2], rows[0] + 9'h1)
		`CHK("no col", cols.size(), 0)
	endtask
	task t_par;
		h.acc(20'h00010, 1, 1);
		h.acc(20'h00010, 0, 0);
		`CHK("quiet", outs.nmi, 1'b0)
		bad = 1;
		h.acc(20'h00010, 0, 0);
		bad = 0;
		h.acc(20'h00010, 0, 0);
		`CHK("nmi", outs.nmi, 1'b1)
		rst_n = 0;
		@(negedge clock) rst_n = 1;
		`CHK("cleared", outs.nmi, 1'b0)
	endtask
	task t_boot;
		for (int v = 0; v < 4; v++) begin
			h.up(v[1:0]);
			`CHK("boot", outs.boot_oe_n, v != 0)
		end
	endtask
	task t_rst;
		reset_in = 0;
		repeat (4) @(negedge clock);
		`CHK("reset", outs.board_reset, 1'b1)
		reset_in = 1;
		repeat (9) @(negedge clock);
		`CHK("reset end", outs.board_reset, 1'b0)
		c = outs.system_clock_out;
		@(negedge clock);
		`CHK("clock out", outs.system_clock_out, ~c)
	endtask
	task t_hold;
		bus_request = 1;
		repeat (5) @(negedge clock);
		`CHK("hold", hold_out, 1'b1)
		`CHK("grant", hold_grant_out, 1'b1)
		bus_request = 0;
		repeat (5) @(negedge clock);
		`CHK("unhold", hold_out, 1'b0)
		`CHK("ungrant", hold_grant_out, 1'b0)
	endtask
	initial begin
		{rst_n, reset_in, bus_request, bad} = 4'h4;
		repeat (8) @(negedge clock);
		rst_n = 1;
		t_acc;
		t_ref;
		t_par;
		t_boot;
		t_rst;
		t_hold;
		test_done;
	end
	initial begin
		#1000000;
		n_mismatch++;
		test_done;
	end
endmodule
